// File: inc/sctl_pkg.sv
// Shared constants and types for the serial controller
`default_nettype none
package sctl_pkg;
	typedef logic [7:0] sctl_addr_t;
	typedef logic [31:0] sctl_word_t;
	typedef enum logic [1:0] {S_IDLE, S_SHIFT, S_SUSP} sctl_state_t;
	// Register byte offsets
	localparam sctl_addr_t OFF_CTRL = 8'h00;
	localparam sctl_addr_t OFF_DIV = 8'h04;
	localparam sctl_addr_t OFF_RX0 = 8'h10;
	localparam sctl_addr_t OFF_RX1 = 8'h14;
	localparam sctl_addr_t OFF_TX0 = 8'h20;
	localparam sctl_addr_t OFF_TX1 = 8'h24;
	localparam sctl_addr_t OFF_PAT = 8'h34;
	localparam sctl_addr_t OFF_STAT = 8'h40;
	localparam sctl_addr_t OFF_MASK = 8'h44;
	// Control field positions
	localparam int B_GO = 0;
	localparam int B_RXNEG = 1;
	localparam int B_TXNEG = 2;
	localparam int B_LEN = 3;
	localparam int B_NUM = 8;
	localparam int B_LSB = 10;
	localparam int B_CLKP = 11;
	localparam int B_SP = 12;
	localparam int B_FLAG = 16;
	localparam int B_IE = 17;
	localparam int B_SLV = 18;
	localparam int B_REO = 19;
	localparam int B_DUAL = 22;
	localparam int B_VAR = 23;
	// Reset values and writable mask
	localparam sctl_word_t CTRL_RST = 32'h0500_0004;
	localparam sctl_word_t CTRL_MASK = 32'h00DF_FFFF;
	localparam sctl_word_t DIV_RST = 32'h0000_0000;
	localparam sctl_word_t PAT_RST = 32'h007F_FF87;
	// Counts and response codes
	localparam logic [5:0] WORD_MAX = 6'h20;
	localparam logic [5:0] LEN16 = 6'h10;
	localparam logic [5:0] LEN24 = 6'h18;
	localparam logic [4:0] SUS_BASE = 5'h02;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// File: inc/sctl_clk_if.sv
// Link between transfer engine and serial clock rate generator
`default_nettype none
interface sctl_clk_if;
	logic run;
	logic varEn;
	logic [15:0] div;
	logic [15:0] div2;
	logic [31:0] pattern;
	logic tick;
	modport gen (input run, input varEn, input div, input div2, input pattern, output tick);
	modport eng (output run, output varEn, output div, output div2, output pattern, input tick);
endinterface
`default_nettype wire

// File: logic/sctl_clkgen.sv
// Serial clock half-period tick generator, fixed or patterned rate
`default_nettype none
module sctl_clkgen (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Engine link
	sctl_clk_if.gen ck
);
	import sctl_pkg::*;

	logic [15:0] cntReg;
	logic [4:0] idxReg;
	logic [15:0] half;

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);

	// Pattern walks one bit per half period, so 32 bits cover a 16-bit word
	always_comb half = (ck.varEn && ck.pattern[idxReg]) ? ck.div2 : ck.div;

	always_ff @(posedge mclk) begin
		if (!rst_b || !ck.run) begin
			cntReg <= 16'h0000;
			idxReg <= 5'h00;
			ck.tick <= 1'b0;
		end else if (cntReg >= half) begin
			cntReg <= 16'h0000;
			idxReg <= idxReg + 5'h01;
			ck.tick <= 1'b1;
		end else begin
			cntReg <= cntReg + 16'h0001;
			ck.tick <= 1'b0;
		end
	end

	fixed_rate_a: assert property (!ck.varEn |-> half == ck.div)
		else $error("Fixed rate does not use primary divisor");
	var_rate_a: assert property (ck.varEn && ck.pattern[idxReg] |-> half == ck.div2)
		else $error("Pattern bit set but second divisor unused");
	// Only judged while the run holds for the whole half period
	tick_gap_a: assert property (ck.tick && ck.run && !ck.varEn && ck.div == 16'h0004
		##1 ck.run [*4] |-> !ck.tick ##1 ck.tick)
		else $error("Tick spacing wrong for divisor four");
endmodule // sctl_clkgen
`default_nettype wire

// File: logic/sctl_top.sv
// Serial controller: AXI4-Lite registers, transfer engine and pin logic
//
// Register access over AXI4-Lite was left to the implementer.
`default_nettype none
// Functional notes
// - Variable mode: rate from pattern and divisors
// - Fixed mode: rate from primary divisor only
// - Dual mode moves two bits per clock
// - Dual mode uses both transmit, receive buffers
// - Mode 00: no reorder, no byte gaps
// - Mode 01: reorder plus byte gaps
// - Mode 10: reorder without byte gaps
// - Mode 11: byte gaps, original order
// - Reorder only for 16, 24, 32 bits
// - Interrupt request only while enabled
// - Slave bit selects external clock, select
// - Completion flag set by hardware, write-one-clear
// - Start bit self-clears on completion
module sctl_top (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// AXI4-Lite write channels
	input wire sctl_pkg::sctl_addr_t s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire sctl_pkg::sctl_word_t s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read channels
	input wire sctl_pkg::sctl_addr_t s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output sctl_pkg::sctl_word_t s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Serial clock and select pins
	input wire logic sclkIn,
	output logic sclkOut,
	output logic sclkOe,
	input wire logic selIn_b,
	output logic selOut_b,
	output logic selOe,
	// Serial data pins
	input wire logic sdi0,
	input wire logic sdi1,
	output logic sdo0,
	output logic sdo1,
	// Interrupt
	output logic irqOut
);
	import sctl_pkg::*;

	sctl_word_t ctrlReg, divReg, patReg, tx0Reg, tx1Reg, rx0Reg, rx1Reg;
	sctl_word_t rxW0Reg, rxW1Reg;
	logic statReg, maskReg;
	sctl_state_t stateReg;
	logic [5:0] bitCntReg, susCntReg;
	logic wordSelReg, pendSusReg;
	logic sclkS1, sclkS2, sclkS3, selS1_b, selS2_b;
	logic sdi0S1, sdi0S2, sdi1S1, sdi1S2;
	logic awHeldReg, wHeldReg;
	sctl_addr_t awAddrReg, rdAddrReg;
	sctl_word_t wDataReg;
	logic [3:0] wStrbReg;

	logic goBusy, rxNeg, txNeg, lsbFirst, clkIdle, flagBit, ieBit;
	logic slaveMode, dualMode, burst2, reoOn, byteEnd;
	logic [4:0] bitLen;
	logic [3:0] spCyc;
	logic [1:0] reoMode;
	logic [5:0] lenVal, susLen, cntInc;
	logic doWrite, doRead, rise, fall, sampleEdge, driveEdge, hold, tog;
	logic wordEnd, nextWord, finish;
	logic [4:0] idx0, idxCur;
	sctl_word_t txSw0, txSw1, txCur, ctrlNext, rdMux;

	sctl_clk_if ck();

	sctl_clkgen uClkgen (
		.mclk(mclk),
		.rst_b(rst_b),
		.ck(ck)
	);

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);

	function automatic logic isMapped(input sctl_addr_t a);
		return a == OFF_CTRL || a == OFF_DIV || a == OFF_RX0 || a == OFF_RX1 ||
			a == OFF_TX0 || a == OFF_TX1 || a == OFF_PAT || a == OFF_STAT || a == OFF_MASK;
	endfunction

	function automatic sctl_word_t applyStrb(input sctl_word_t old, input sctl_word_t d,
		input logic [3:0] s);
		sctl_word_t r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Byte reversal within the active word; self-inverse for every length
	function automatic sctl_word_t reorderWord(input sctl_word_t w, input logic en,
		input logic [5:0] len);
		sctl_word_t r;
		r = w;
		if (en) begin
			if (len == LEN16) begin
				r = {16'h0000, w[7:0], w[15:8]};
			end else if (len == LEN24) begin
				r = {8'h00, w[7:0], w[15:8], w[23:16]};
			end else begin
				r = {w[7:0], w[15:8], w[23:16], w[31:24]};
			end
		end
		return r;
	endfunction

	function automatic logic [4:0] bitIdx(input logic [5:0] cnt, input logic [5:0] len,
		input logic lsb);
		logic [5:0] t;
		t = len - 6'h01 - cnt;
		return lsb ? cnt[4:0] : t[4:0];
	endfunction

	// Control fields
	assign goBusy = ctrlReg[B_GO];
	assign rxNeg = ctrlReg[B_RXNEG];
	assign txNeg = ctrlReg[B_TXNEG];
	assign bitLen = ctrlReg[B_LEN +: 5];
	assign burst2 = ctrlReg[B_NUM];
	assign lsbFirst = ctrlReg[B_LSB];
	assign clkIdle = ctrlReg[B_CLKP];
	assign spCyc = ctrlReg[B_SP +: 4];
	assign flagBit = ctrlReg[B_FLAG];
	assign ieBit = ctrlReg[B_IE];
	assign slaveMode = ctrlReg[B_SLV];
	assign reoMode = ctrlReg[B_REO +: 2];
	assign dualMode = ctrlReg[B_DUAL];

	// Rate generator runs only while mastering a transfer
	assign ck.run = stateReg != S_IDLE && !slaveMode;
	assign ck.varEn = ctrlReg[B_VAR] && !slaveMode;
	assign ck.div = divReg[15:0];
	assign ck.div2 = divReg[31:16];
	assign ck.pattern = patReg;

	always_comb begin
		lenVal = (bitLen == 5'h00) ? WORD_MAX : {1'b0, bitLen};
		reoOn = !reoMode[0] ^ !reoMode[1] &&
			(lenVal == LEN16 || lenVal == LEN24 || lenVal == WORD_MAX);
		susLen = {{1'b0, spCyc} + SUS_BASE, 1'b0};
		cntInc = bitCntReg + 6'h01;
		byteEnd = cntInc[2:0] == 3'h0 && cntInc < lenVal;
		idx0 = bitIdx(6'h00, lenVal, lsbFirst);
		idxCur = bitIdx(bitCntReg, lenVal, lsbFirst);
		txSw0 = reorderWord(tx0Reg, reoOn, lenVal);
		txSw1 = reorderWord(tx1Reg, reoOn, lenVal);
		txCur = (wordSelReg && !dualMode) ? txSw1 : txSw0;
		hold = (bitCntReg == lenVal || pendSusReg) && sclkOut == clkIdle;
		tog = ck.tick && stateReg == S_SHIFT && !hold;
		rise = slaveMode ? sclkS2 && !sclkS3 && !selS2_b && stateReg == S_SHIFT
			: tog && !sclkOut;
		fall = slaveMode ? !sclkS2 && sclkS3 && !selS2_b && stateReg == S_SHIFT
			: tog && sclkOut;
		sampleEdge = (rxNeg ? fall : rise) && bitCntReg != lenVal;
		driveEdge = (txNeg ? fall : rise) && bitCntReg != lenVal;
		wordEnd = stateReg == S_SHIFT && goBusy && bitCntReg == lenVal &&
			(slaveMode || sclkOut == clkIdle);
		// Dual mode ignores the burst count; software keeps it at one word
		nextWord = !dualMode && burst2 && !wordSelReg;
		finish = wordEnd && !nextWord;
		doWrite = awHeldReg && wHeldReg && !s_axi_bvalid;
		doRead = s_axi_arvalid && s_axi_arready;
	end

	// Pin synchronisers; first stage feeds only the second
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			sclkS1 <= 1'b0;
			sclkS2 <= 1'b0;
			sclkS3 <= 1'b0;
			selS1_b <= 1'b1;
			selS2_b <= 1'b1;
			sdi0S1 <= 1'b0;
			sdi0S2 <= 1'b0;
			sdi1S1 <= 1'b0;
			sdi1S2 <= 1'b0;
		end else begin
			sclkS1 <= sclkIn;
			sclkS2 <= sclkS1;
			sclkS3 <= sclkS2;
			selS1_b <= selIn_b;
			selS2_b <= selS1_b;
			sdi0S1 <= sdi0;
			sdi0S2 <= sdi0S1;
			sdi1S1 <= sdi1;
			sdi1S2 <= sdi1S1;
		end
	end

	// Transfer sequencer
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			stateReg <= S_IDLE;
			bitCntReg <= 6'h00;
			susCntReg <= 6'h00;
			wordSelReg <= 1'b0;
			pendSusReg <= 1'b0;
			rxW0Reg <= 32'h0000_0000;
			rxW1Reg <= 32'h0000_0000;
		end else begin
			unique case (stateReg)
				S_IDLE: begin
					if (goBusy) begin
						stateReg <= S_SHIFT;
						bitCntReg <= 6'h00;
						wordSelReg <= 1'b0;
						pendSusReg <= 1'b0;
						rxW0Reg <= 32'h0000_0000;
						rxW1Reg <= 32'h0000_0000;
					end
				end
				S_SHIFT: begin
					if (!goBusy) begin
						stateReg <= S_IDLE;
					end else if (wordEnd) begin
						if (nextWord) begin
							wordSelReg <= 1'b1;
							bitCntReg <= 6'h00;
							rxW0Reg <= 32'h0000_0000;
							susCntReg <= 6'h00;
							stateReg <= slaveMode ? S_SHIFT : S_SUSP;
						end else begin
							stateReg <= S_IDLE;
						end
					end else if (pendSusReg && sclkOut == clkIdle) begin
						pendSusReg <= 1'b0;
						susCntReg <= 6'h00;
						stateReg <= S_SUSP;
					end else if (sampleEdge) begin
						bitCntReg <= cntInc;
						rxW0Reg[idxCur] <= sdi0S2;
						if (dualMode) begin
							rxW1Reg[idxCur] <= sdi1S2;
						end
						// Byte gaps are a master feature; mode 00 and 10 never set this
						if (byteEnd && reoMode[0] && !slaveMode) begin
							pendSusReg <= 1'b1;
						end
					end
				end
				S_SUSP: begin
					if (!goBusy) begin
						stateReg <= S_IDLE;
					end else if (ck.tick) begin
						if (susCntReg == susLen - 6'h01) begin
							stateReg <= S_SHIFT;
						end else begin
							susCntReg <= susCntReg + 6'h01;
						end
					end
				end
				default: stateReg <= S_IDLE;
			endcase
		end
	end

	// Receive buffers take the finished word
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			rx0Reg <= 32'h0000_0000;
			rx1Reg <= 32'h0000_0000;
		end else if (wordEnd) begin
			if (dualMode) begin
				rx0Reg <= reorderWord(rxW0Reg, reoOn, lenVal);
				rx1Reg <= reorderWord(rxW1Reg, reoOn, lenVal);
			end else if (wordSelReg) begin
				rx1Reg <= reorderWord(rxW0Reg, reoOn, lenVal);
			end else begin
				rx0Reg <= reorderWord(rxW0Reg, reoOn, lenVal);
			end
		end
	end

	// Serial data out, first bit preloaded before the first edge
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			sdo0 <= 1'b0;
			sdo1 <= 1'b0;
		end else begin
			if (stateReg == S_IDLE && goBusy) begin
				sdo0 <= txSw0[idx0];
				sdo1 <= txSw1[idx0];
			end else if (wordEnd && nextWord) begin
				sdo0 <= txSw1[idx0];
			end else if (driveEdge) begin
				sdo0 <= txCur[idxCur];
				sdo1 <= txSw1[idxCur];
			end
			if (!dualMode) begin
				sdo1 <= 1'b0;
			end
		end
	end

	// Clock and select pins; slave leaves them undriven
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			sclkOut <= 1'b0;
			sclkOe <= 1'b0;
			selOut_b <= 1'b1;
			selOe <= 1'b0;
		end else begin
			sclkOe <= !slaveMode;
			selOe <= !slaveMode;
			selOut_b <= slaveMode || stateReg == S_IDLE;
			if (slaveMode || stateReg == S_IDLE) begin
				sclkOut <= clkIdle;
			end else if (tog) begin
				sclkOut <= !sclkOut;
			end
		end
	end

	always_comb begin
		ctrlNext = applyStrb(ctrlReg, wDataReg, wStrbReg) & CTRL_MASK;
		ctrlNext[B_FLAG] = flagBit && !(wStrbReg[2] && wDataReg[B_FLAG]);
	end

	// Control register: completion wins over a same-cycle clear
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			ctrlReg <= CTRL_RST & CTRL_MASK;
		end else begin
			if (doWrite && awAddrReg == OFF_CTRL) begin
				ctrlReg <= ctrlNext;
			end
			if (finish) begin
				ctrlReg[B_GO] <= 1'b0;
				ctrlReg[B_FLAG] <= 1'b1;
			end
		end
	end

	// Plain software registers
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			divReg <= DIV_RST;
			patReg <= PAT_RST;
			tx0Reg <= 32'h0000_0000;
			tx1Reg <= 32'h0000_0000;
			maskReg <= 1'b0;
		end else if (doWrite) begin
			unique case (awAddrReg)
				OFF_DIV: divReg <= applyStrb(divReg, wDataReg, wStrbReg);
				OFF_PAT: patReg <= applyStrb(patReg, wDataReg, wStrbReg);
				OFF_TX0: tx0Reg <= applyStrb(tx0Reg, wDataReg, wStrbReg);
				OFF_TX1: tx1Reg <= applyStrb(tx1Reg, wDataReg, wStrbReg);
				OFF_MASK: maskReg <= wStrbReg[0] ? wDataReg[0] : maskReg;
				default: maskReg <= maskReg;
			endcase
		end
	end

	// Interrupt status: read clears, a new completion wins
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			statReg <= 1'b0;
			irqOut <= 1'b0;
		end else begin
			if (finish) begin
				statReg <= 1'b1;
			end else if (doRead && s_axi_araddr == OFF_STAT) begin
				statReg <= 1'b0;
			end
			irqOut <= ieBit && statReg && maskReg;
		end
	end

	// AXI4-Lite write side; address and data accepted in either order
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OK;
			awHeldReg <= 1'b0;
			wHeldReg <= 1'b0;
			awAddrReg <= 8'h00;
			wDataReg <= 32'h0000_0000;
			wStrbReg <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awAddrReg <= s_axi_awaddr;
				awHeldReg <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wDataReg <= s_axi_wdata;
				wStrbReg <= s_axi_wstrb;
				wHeldReg <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (doWrite) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= isMapped(awAddrReg) ? RESP_OK : RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				awHeldReg <= 1'b0;
				wHeldReg <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	always_comb begin
		case (s_axi_araddr)
			OFF_CTRL: rdMux = ctrlReg;
			OFF_DIV: rdMux = divReg;
			OFF_RX0: rdMux = rx0Reg;
			OFF_RX1: rdMux = rx1Reg;
			OFF_PAT: rdMux = patReg;
			OFF_STAT: rdMux = {31'h0000_0000, statReg};
			OFF_MASK: rdMux = {31'h0000_0000, maskReg};
			default: rdMux = 32'h0000_0000;
		endcase
	end

	// AXI4-Lite read side
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OK;
			rdAddrReg <= 8'h00;
		end else begin
			if (doRead) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rdMux;
				s_axi_rresp <= isMapped(s_axi_araddr) ? RESP_OK : RESP_SLVERR;
				rdAddrReg <= s_axi_araddr;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	flag_set_a: assert property (finish |=> flagBit && statReg)
		else $error("Completion did not set the flag");
	busy_clear_a: assert property (finish |=> !goBusy ##1 stateReg == S_IDLE)
		else $error("Start bit not cleared after completion");
	irq_gate_a: assert property (!ieBit [*2] |-> !irqOut)
		else $error("Interrupt raised while disabled");
	irq_raise_a: assert property (ieBit && statReg && maskReg |=> irqOut)
		else $error("Enabled interrupt not raised");
	slave_pins_a: assert property (slaveMode [*2] |-> !sclkOe && !selOe && selOut_b)
		else $error("Slave drives clock or select");
	dual_line_a: assert property (!dualMode [*2] |-> !sdo1)
		else $error("Second data line active outside dual mode");
	no_gap_a: assert property (stateReg == S_SUSP |-> reoMode[0] || burst2)
		else $error("Suspend without byte gap or burst");
	gap_len_a: assert property (stateReg == S_SUSP |-> susCntReg < susLen)
		else $error("Suspend interval overran");
	plain_order_a: assert property (wordEnd && !wordSelReg && !dualMode && !reoOn
		|=> rx0Reg == $past(rxW0Reg))
		else $error("Bytes reordered while reorder is off");
	swap_order_a: assert property (wordEnd && !wordSelReg && !dualMode && reoOn
		&& lenVal == WORD_MAX |=> rx0Reg[7:0] == $past(rxW0Reg[31:24]))
		else $error("Bytes not reordered");
	reserved_a: assert property (s_axi_rvalid && rdAddrReg == OFF_CTRL
		|-> s_axi_rdata[31:24] == 8'h00 && !s_axi_rdata[21])
		else $error("Reserved control bits read nonzero");

	master_done_c: cover property (finish && !slaveMode);
	slave_done_c: cover property (finish && slaveMode);
	dual_done_c: cover property (finish && dualMode);
	byte_gap_c: cover property (stateReg == S_SUSP && reoMode[0]);
endmodule // sctl_top
`default_nettype wire

// File: verif/sctl_peer.sv
// Behavioural off-chip serial peripheral facing the controller in master mode
`default_nettype none
module sctl_peer (
	// Serial pins
	input wire logic sclk,
	input wire logic sel_b,
	input wire logic mosi0,
	input wire logic mosi1,
	output logic miso0,
	output logic miso1,
	// Test side
	input wire logic [31:0] reply0,
	input wire logic [31:0] reply1,
	output logic [31:0] got0,
	output logic [31:0] got1,
	output var int edges
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] sh0;
	logic [31:0] sh1;
	initial begin
		miso0 = 1'b0;
		miso1 = 1'b0;
		got0 = 32'h0000_0000;
		got1 = 32'h0000_0000;
		edges = 0;
	end
	// First bit must be on the line before the first rising edge
	always @(negedge sel_b) begin
		sh0 = reply0;
		sh1 = reply1;
		edges = 0;
		miso0 = reply0[31];
		miso1 = reply1[31];
	end
	// Sample on rise, shift on fall: device drives on the falling edge
	always @(posedge sclk) if (!sel_b) begin
		got0 = {got0[30:0], mosi0};
		got1 = {got1[30:0], mosi1};
		edges++;
	end
	always @(negedge sclk) if (!sel_b) begin
		sh0 = sh0 << 1;
		sh1 = sh1 << 1;
		miso0 = sh0[31];
		miso1 = sh1[31];
	end
	// Released lines have no pull: they must not keep the last bit
	always @(posedge sel_b) begin
		miso0 = ~miso0;
		miso1 = ~miso1;
	end
endmodule // sctl_peer
`default_nettype wire

// File: verif/testbench.sv
// Self-checking bench for the serial controller
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import sctl_pkg::*;
	logic mclk, rst_b, sclkIn, selIn_b, slvData, sclkPrev, peerMiso0;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	sctl_addr_t s_axi_awaddr, s_axi_araddr;
	sctl_word_t s_axi_wdata, s_axi_rdata, rd, reply0, reply1, got0, got1;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic sclkOut, sclkOe, selOut_b, selOe, sdi0, sdi1, sdo0, sdo1, irqOut;
	int mismatches, totalChecks, edges, lastT, halfP, maxGap, cyc;
	assign sdi0 = selIn_b ? peerMiso0 : slvData;
	sctl_top dut (.mclk(mclk), .rst_b(rst_b),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sclkIn(sclkIn),
		.sclkOut(sclkOut), .sclkOe(sclkOe), .selIn_b(selIn_b), .selOut_b(selOut_b), .selOe(selOe),
		.sdi0(sdi0), .sdi1(sdi1), .sdo0(sdo0), .sdo1(sdo1), .irqOut(irqOut));
	sctl_peer peer (.sclk(sclkOut), .sel_b(selOut_b), .mosi0(sdo0), .mosi1(sdo1),
		.miso0(peerMiso0), .miso1(sdi1), .reply0(reply0), .reply1(reply1), .got0(got0),
		.got1(got1), .edges(edges));
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	// Serial clock toggle spacing in system clocks, measured only inside frames
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		sclkPrev <= sclkOut;
		if (selOut_b) lastT <= cyc;
		else if (sclkOut !== sclkPrev) begin
			halfP <= cyc - lastT;
			lastT <= cyc;
			if (cyc - lastT > maxGap) maxGap <= cyc - lastT;
		end
	end
	task automatic testDone();
		$display("Checks %0d, mismatches %0d", totalChecks, mismatches);
		if (mismatches == 0 && totalChecks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string name, input sctl_word_t exp, input sctl_word_t got);
		totalChecks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic axw(input sctl_addr_t a, input sctl_word_t d);
		int n;
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge mclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (n == 50) chk("write answer", 0, 1);
	endtask
	task automatic axr(input sctl_addr_t a);
		int n;
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge mclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (n == 50) chk("read answer", 0, 1);
	endtask
	// Polling keeps the bus busy; fine since reads never stall the engine
	task automatic waitDone();
		for (int n = 0; n < 300; n++) begin
			axr(OFF_CTRL);
			if (rd[B_GO] === 1'b0) break;
		end
		if (rd[B_GO] !== 1'b0) chk("done in time", 0, 1);
	endtask
	task automatic xfer(input sctl_word_t tx, input sctl_word_t ctrl);
		axw(OFF_TX0, tx);
		maxGap = 0;
		axw(OFF_CTRL, ctrl);
		waitDone();
		axr(OFF_STAT);
		axw(OFF_CTRL, (ctrl & 32'hFFFF_FFFE) | 32'h0001_0000);
	endtask
	initial begin
		repeat (40000) @(posedge mclk);
		mismatches++;
		testDone();
	end
	initial begin
		{rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
		{sclkIn, slvData, sclkPrev, selIn_b} = 4'h1;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0000_0000;
		s_axi_wstrb = 4'hF;
		reply0 = 32'h3C00_0000;
		reply1 = 32'hA500_0000;
		{mismatches, totalChecks, cyc, lastT, halfP, maxGap} = '0;
		repeat (3) @(posedge mclk);
		rst_b <= 1'b1;
		axr(OFF_CTRL);
		chk("ctrl reset", 32'h0000_0004, rd);
		axw(OFF_CTRL, 32'hFF20_0004);
		axr(OFF_CTRL);
		chk("ctrl reserved", 32'h0000_0004, rd);
		axr(8'hFC);
		chk("unmapped resp", RESP_SLVERR, rsp);
		axw(8'hFC, 32'h0000_0001);
		chk("unmapped write", RESP_SLVERR, rsp);
		axw(OFF_MASK, 32'h0000_0001);
		chk("write resp", RESP_OK, rsp);
		axw(OFF_DIV, 32'h0009_0004);
		// Byte transfer with interrupt enabled, second divisor present but unused
		axw(OFF_TX0, 32'h0000_00A5);
		axw(OFF_CTRL, 32'h0002_0045);
		waitDone();
		chk("peer byte", 32'h0000_00A5, got0[7:0]);
		chk("fixed half period", 5, halfP);
		chk("irq raised", 1, irqOut);
		axr(OFF_RX0);
		chk("rx byte", 32'h0000_003C, rd);
		axr(OFF_CTRL);
		chk("flag set", 32'h0003_0044, rd);
		axr(OFF_STAT);
		chk("status", 32'h0000_0001, rd);
		@(posedge mclk);
		chk("irq cleared", 0, irqOut);
		axw(OFF_CTRL, 32'h0001_0044);
		axr(OFF_CTRL);
		chk("flag cleared", 32'h0000_0044, rd);
		// Every byte order mode on a 32-bit word
		for (int m = 0; m < 4; m++) begin
			xfer(32'h1122_3344, {11'h000, m[1:0], 19'h0_0005});
			chk("byte order", (m == 1 || m == 2) ? 32'h4433_2211 : 32'h1122_3344, got0);
			chk("byte gap", m[0], (maxGap >= 20) ? 1 : ((maxGap <= 7) ? 0 : 2));
			chk("irq disabled", 0, irqOut);
		end
		xfer(32'h0000_0ABC, 32'h0010_0065);
		chk("twelve bits kept", 32'h0000_0ABC, got0[11:0]);
		// Least significant bit first, seen reversed by the peer
		xfer(32'h0000_00B1, 32'h0000_0445);
		chk("lsb first", 32'h0000_008D, got0[7:0]);
		axw(OFF_PAT, 32'hFFFF_FFFF);
		xfer(32'h0000_1234, 32'h0080_0085);
		chk("variable half period", 10, halfP);
		axw(OFF_TX1, 32'h0000_00C3);
		xfer(32'h0000_005A, 32'h0040_0045);
		chk("dual line0", 32'h0000_005A, got0[7:0]);
		chk("dual line1", 32'h0000_00C3, got1[7:0]);
		chk("dual clocks", 8, edges);
		axr(OFF_RX1);
		chk("dual rx1", 32'h0000_00A5, rd);
		// Slave byte clocked by the bench, 400 ns serial period
		axw(OFF_CTRL, 32'h0004_0045);
		repeat (2) @(posedge mclk);
		chk("slave pins released", 0, {sclkOe, selOe});
		selIn_b <= 1'b0;
		for (int i = 7; i >= 0; i--) begin
			slvData <= 1'((8'h96 >> i) & 8'h01);
			repeat (4) @(posedge mclk);
			sclkIn <= 1'b1;
			repeat (4) @(posedge mclk);
			sclkIn <= 1'b0;
		end
		repeat (4) @(posedge mclk);
		selIn_b <= 1'b1;
		waitDone();
		axr(OFF_RX0);
		chk("slave rx", 32'h0000_0096, rd);
		testDone();
	end
endmodule // testbench
`default_nettype wire
